// *** rtl/timer16_pkg.sv ***
package timer16_pkg;
  localparam logic [7:0] UNIT_STRIDE = 8'h40;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT_LO = 8'h04;
  localparam logic [7:0] OFS_CNT_HI = 8'h08;
  localparam logic [7:0] OFS_CMPA_LO = 8'h0C;
  localparam logic [7:0] OFS_CMPA_HI = 8'h10;
  localparam logic [7:0] OFS_CMPB_LO = 8'h14;
  localparam logic [7:0] OFS_CMPB_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h80;
  localparam logic [7:0] OFS_MASK = 8'h84;

  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_DIV1 = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_DIV256 = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_RISE = 3'h7;

  localparam int PRE_W = 10;
  localparam logic [9:0] MSK_DIV8 = 10'h007;
  localparam logic [9:0] MSK_DIV16 = 10'h00F;
  localparam logic [9:0] MSK_DIV32 = 10'h01F;
  localparam logic [9:0] MSK_DIV64 = 10'h03F;
  localparam logic [9:0] MSK_DIV256 = 10'h0FF;
  localparam logic [9:0] MSK_DIV1024 = 10'h3FF;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [15:0] cnt;
    logic [15:0] oca;
    logic [15:0] ocb;
    logic blk;
  } unit_s;

  localparam unit_s UNIT_RESET = '{sel: SEL_STOP, cnt: CNT_RESET, oca: CNT_RESET,
                                   ocb: CNT_RESET, blk: 1'b0};
endpackage

// *** rtl/timer16_clock_select_compare_regs.sv ***
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module timer16_clock_select_compare_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic unit1_ext_count_pin,
  output logic [3:0] compare_output_pin,
  output logic irq
);
  import timer16_pkg::*;

  unit_s u [2];
  unit_s next_u [2];
  logic [PRE_W-1:0] pre, next_pre;
  logic [7:0] temp, next_temp;
  logic [3:0] status, next_status, mask, next_mask, next_pin, set_ev;
  logic ext_s1, ext_s2, ext_s3;
  logic [1:0] tick, cnt_load;
  logic hi_wr;
  logic [7:0] aw_q;
  logic [7:0] next_aw_q;
  logic [7:0] wd_q, next_wd_q;
  logic wlane_q, next_wlane_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_irq;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // prescaled codes fire when the masked prescaler bits are all ones
  function automatic logic sel_tick(input logic [2:0] sel, input logic unit3,
                                    input logic [PRE_W-1:0] p, input logic fall,
                                    input logic rise);
    logic t;
    t = 1'b0;
    unique case (sel)
      SEL_STOP: t = 1'b0;
      SEL_DIV1: t = 1'b1;
      SEL_DIV8: t = (p & MSK_DIV8) == MSK_DIV8;
      SEL_DIV64: t = (p & MSK_DIV64) == MSK_DIV64;
      SEL_DIV256: t = (p & MSK_DIV256) == MSK_DIV256;
      SEL_DIV1024: t = (p & MSK_DIV1024) == MSK_DIV1024;
      SEL_EXT_FALL: t = unit3 ? ((p & MSK_DIV16) == MSK_DIV16) : fall;
      SEL_EXT_RISE: t = unit3 ? ((p & MSK_DIV32) == MSK_DIV32) : rise;
    endcase
    return t;
  endfunction

  always_comb begin
    logic [7:0] base;
    logic [7:0] ra;
    logic [7:0] wa;
    logic fire;
    logic hit;
    base = 8'h00;
    ra = 8'h00;
    wa = 8'h00;
    fire = 1'b0;
    hit = 1'b0;
    next_u = u;
    next_pre = pre + 1'b1;
    next_temp = temp;
    next_status = status;
    next_mask = mask;
    set_ev = 4'h0;
    cnt_load = 2'h0;
    hi_wr = 1'b0;
    tick = 2'h0;
    next_aw_q = aw_q;
    next_wd_q = wd_q;
    next_wlane_q = wlane_q;
    next_awready = awready;
    next_wready = wready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;

    // count ticks and compare; the pin edge is seen on the sync pair only,
    // so the pin direction never matters
    for (int i = 0; i < 2; i++) begin
      tick[i] = sel_tick(u[i].sel, i[0], pre, ext_s3 & ~ext_s2, ext_s2 & ~ext_s3);
      if (tick[i]) begin
        next_u[i].cnt = u[i].cnt + 16'h0001;
        next_u[i].blk = 1'b0;
        if (!u[i].blk) begin
          set_ev[2*i] = u[i].cnt == u[i].oca;
          set_ev[2*i+1] = u[i].cnt == u[i].ocb;
        end
      end
    end

    // read channel: one-cycle answer, status clears on read
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      hit = 1'b0;
      if (araddr == OFS_STATUS) begin
        next_rdata[3:0] = status;
        next_status = 4'h0;
        hit = 1'b1;
      end
      if (araddr == OFS_MASK) begin
        next_rdata[3:0] = mask;
        hit = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        base = i[0] ? UNIT_STRIDE : 8'h00;
        ra = araddr - base;
        if (araddr[7] == 1'b0 && araddr[6] == i[0]) begin
          hit = 1'b1;
          unique case (ra)
            OFS_CTRL: next_rdata[SEL_W-1:0] = u[i].sel;
            OFS_CNT_LO: begin
              next_rdata[7:0] = u[i].cnt[7:0];
              next_temp = u[i].cnt[15:8];
            end
            OFS_CNT_HI: next_rdata[7:0] = temp;
            OFS_CMPA_LO: next_rdata[7:0] = u[i].oca[7:0];
            OFS_CMPA_HI: next_rdata[7:0] = u[i].oca[15:8];
            OFS_CMPB_LO: next_rdata[7:0] = u[i].ocb[7:0];
            OFS_CMPB_HI: next_rdata[7:0] = u[i].ocb[15:8];
            default: hit = 1'b0;
          endcase
        end
      end
      if (!hit) begin
        next_rresp = RESP_SLVERR;
      end
    end

    // write channel: address and data held until both are in
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    fire = !awready && !wready && !bvalid;
    if (fire) begin
      next_awready = 1'b1;
      next_wready = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      hit = (aw_q == OFS_STATUS) || (aw_q == OFS_MASK);
      if (aw_q == OFS_MASK && wlane_q) begin
        next_mask = wd_q[3:0];
      end
      for (int i = 0; i < 2; i++) begin
        base = i[0] ? UNIT_STRIDE : 8'h00;
        wa = aw_q - base;
        if (aw_q[7] == 1'b0 && aw_q[6] == i[0]) begin
          hit = hit || wa <= OFS_CMPB_HI;
          if (wlane_q) begin
            unique case (wa)
              OFS_CTRL: next_u[i].sel = wd_q[SEL_W-1:0];
              OFS_CNT_LO: begin
                next_u[i].cnt = {temp, wd_q};
                next_u[i].blk = 1'b1;
                cnt_load[i] = 1'b1;
              end
              OFS_CMPA_LO: next_u[i].oca = {temp, wd_q};
              OFS_CMPB_LO: next_u[i].ocb = {temp, wd_q};
              OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI: begin
                next_temp = wd_q;
                hi_wr = 1'b1;
              end
              default: next_temp = temp;
            endcase
          end
        end
      end
      if (!hit) begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_aw_q = awaddr;
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_wd_q = wdata[7:0];
      next_wlane_q = wstrb[0];
    end

    // a match in the clearing read still lands
    next_status = next_status | set_ev;
    next_pin = compare_output_pin ^ set_ev;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      u <= '{default: UNIT_RESET};
      pre <= '0;
      temp <= 8'h00;
      status <= 4'h0;
      mask <= 4'h0;
      compare_output_pin <= 4'h0;
      irq <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      wlane_q <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      u <= next_u;
      pre <= next_pre;
      temp <= next_temp;
      status <= next_status;
      mask <= next_mask;
      compare_output_pin <= next_pin;
      irq <= next_irq;
      ext_s1 <= unit1_ext_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      aw_q <= next_aw_q;
      wd_q <= next_wd_q;
      wlane_q <= next_wlane_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  a_stopped_hold: assert property (@(posedge clk) disable iff (rst)
    u[0].sel == SEL_STOP && !cnt_load[0] |=> $stable(u[0].cnt))
    else $error("stopped counter moved");
  a_div1024_tick: assert property (@(posedge clk) disable iff (rst)
    u[0].sel == SEL_DIV1024 && tick[0] |-> pre == MSK_DIV1024)
    else $error("div1024 tick off prescaler wrap");
  a_ext_fall_edge: assert property (@(posedge clk) disable iff (rst)
    u[0].sel == SEL_EXT_FALL |-> tick[0] == (ext_s3 && !ext_s2))
    else $error("falling edge tick mismatch");
  a_unit3_div16: assert property (@(posedge clk) disable iff (rst)
    u[1].sel == SEL_EXT_FALL |-> tick[1] == (pre[3:0] == 4'hF))
    else $error("unit3 div16 tick wrong");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    tick[0] && !cnt_load[0] |=> u[0].cnt == $past(u[0].cnt) + 16'h0001)
    else $error("counter did not step by one");
  a_cnt_atomic: assert property (@(posedge clk) disable iff (rst)
    cnt_load[1] |=> u[1].cnt == {$past(temp), $past(wd_q)} && u[1].blk)
    else $error("counter load not atomic");
  a_temp_capture: assert property (@(posedge clk) disable iff (rst)
    hi_wr |=> temp == $past(wd_q))
    else $error("high byte latch not loaded");
  a_match_block: assert property (@(posedge clk) disable iff (rst)
    tick[0] && u[0].blk |-> set_ev[1:0] == 2'h0)
    else $error("match not blocked after counter write");
  a_flag_next: assert property (@(posedge clk) disable iff (rst)
    tick[0] && !u[0].blk && u[0].cnt == u[0].oca |=> status[0] && $changed(compare_output_pin[0]))
    else $error("match flag missing after equal count");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == |(status & mask))
    else $error("irq does not follow masked status");
endmodule

// *** sim/ext_pin_model.sv ***
`timescale 1ns/1ps
module ext_pin_model (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // software drives the pin as an output; edges must still count
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// *** sim/timer16_clock_select_compare_regs_tb.sv ***
`timescale 1ns/1ps
module timer16_clock_select_compare_regs_tb;
  import timer16_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, pin;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [15:0] v;
  logic [3:0] compare_output_pin, p0;
  int fails = 0, compares = 0, cycles = 0;

  always #5 clk = ~clk;

  ext_pin_model ext_pin_model_i (.clk(clk), .pin(pin));
  timer16_clock_select_compare_regs timer16_clock_select_compare_regs_i (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .unit1_ext_count_pin(pin), .compare_output_pin(compare_output_pin), .irq(irq));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    logic ad, dd;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    do begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    x = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // high byte goes to the shared latch first, the low write commits both
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr(a + 8'h04, x[15:8]);
    wr(a, x[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    logic [31:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    x = {hi[7:0], lo[7:0]};
  endtask

  task automatic t_regs();
    rd16(UNIT_STRIDE + OFS_CMPB_LO, v);
    chk(v, 16'h0000);
    wr16(UNIT_STRIDE + OFS_CNT_LO, 16'hbeef);
    chk(resp, RESP_OKAY);
    rd16(UNIT_STRIDE + OFS_CNT_LO, v);
    chk(v, 16'hbeef);
    wr(UNIT_STRIDE + OFS_CNT_HI, 8'hab);
    wr(OFS_CMPB_LO, 8'h01);
    rd16(OFS_CMPB_LO, v);
    chk(v, 16'hab01);
    rd(8'h30, d);
    chk(resp, RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(8'h3c, 8'h11);
    chk(resp, RESP_SLVERR);
    // a write with lane 0 off is answered but must leave the mask alone
    wstrb <= 4'h0;
    wr(OFS_MASK, 8'h0f);
    wstrb <= 4'hf;
    rd(OFS_MASK, d);
    chk(d, 32'h0000_0000);
  endtask

  // counter is stopped before the read-back so the checked count holds still
  task automatic t_rate(input logic [7:0] b, input logic [2:0] c, input int dv);
    wr16(b + OFS_CNT_LO, 16'h0000);
    wr(b + OFS_CTRL, {5'h00, c});
    repeat (dv == 0 ? 8 : 4 * dv) @(posedge clk);
    wr(b + OFS_CTRL, {5'h00, SEL_STOP});
    rd16(b + OFS_CNT_LO, v);
    if (dv == 0)
      chk(v, 16'h0000);
    else
      chk(v >= 4 && v <= (dv == 1 ? 12 : 5), 1);
  endtask

  task automatic t_ext(input logic [2:0] c);
    wr16(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL, {5'h00, c});
    ext_pin_model_i.pulses(6);
    repeat (8) @(posedge clk);
    wr(OFS_CTRL, {5'h00, SEL_STOP});
    rd16(OFS_CNT_LO, v);
    chk(v, 16'h0006);
  endtask

  // compare B stays 0: the count write must hide the match at 0
  task automatic t_match(input logic [7:0] m);
    wr(OFS_MASK, m);
    p0 = compare_output_pin;
    wr16(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL, {5'h00, SEL_DIV1});
    repeat (20) @(posedge clk);
    wr(OFS_CTRL, {5'h00, SEL_STOP});
    chk(compare_output_pin, p0 ^ 4'h1);
    chk(irq, m[0]);
    rd(OFS_STATUS, d);
    chk(d, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b0);
    rd(OFS_STATUS, d);
    chk(d, 32'h0000_0000);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    for (int c = 0; c < 6; c++)
      t_rate(OFS_CTRL, c[2:0], c == 0 ? 0 : c == 1 ? 1 : c == 2 ? 8 : 4 ** c);
    for (int c = 0; c < 8; c++)
      t_rate(UNIT_STRIDE, c[2:0], c == 0 ? 0 : c == 1 ? 1 : c == 2 ? 8 :
             c == 6 ? 16 : c == 7 ? 32 : 4 ** c);
    t_ext(SEL_EXT_FALL);
    t_ext(SEL_EXT_RISE);
    rd(OFS_STATUS, d);
    wr16(OFS_CMPA_LO, 16'h0005);
    wr16(OFS_CMPB_LO, 16'h0000);
    t_match(8'h00);
    t_match(8'h0f);
    print_verdict();
  end
endmodule
